// File: fieldbus_indicator_leds.sv
// Contract
// R01 - A port indicator is steadily lit on a valid idle link and dark on an invalid link.
// R02 - A port indicator flickers while its valid link carries traffic.
// R03 - There are separate indicators for the incoming and outgoing port, each following only its own port.
// R04 - The status LED is steadily lit in OPERATIONAL.
// R05 - In PRE-OPERATIONAL the status LED blinks 200 ms on and 200 ms off.
// R06 - In SAFE-OPERATIONAL the status LED flashes 200 ms on then stays 1000 ms off, repeating.
// R07 - The status LED flickers 50 ms on and 50 ms off while booting before INIT, in BOOTSTRAP and during firmware download.
// R08 - The status LED is dark in INIT.
// R09 - The error LED is steadily lit after a process data interface watchdog timeout.
// R10 - The error LED blinks 200 ms on and 200 ms off on a general configuration error.
// R11 - The error LED flickers 50 ms on and 50 ms off when INIT is reached with the change indication set to change/error.
// R12 - The error LED is driven through the two-wire serial data lines, not a dedicated output.
// R13 - All patterns run from one shared millisecond tick and restart in their on phase when the pattern changes.
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_led_map.svh"

module fieldbus_indicator_leds #(
  parameter int MS_CYCLES = `REF_CLK_HZ / 1000000 * `MS_PERIOD_US
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire fieldbus_led_pkg::port_link_t PORT_IN,
  input wire fieldbus_led_pkg::port_link_t PORT_OUT,
  input wire logic [`AL_STATE_W-1:0] AL_STATE,
  input wire logic AL_CHANGE_FLAG,
  input wire logic FW_DOWNLOAD,
  input wire logic PDI_WDOG_TIMEOUT,
  input wire logic CONFIG_ERROR,
  input wire logic ERROR_ACK,
  output logic PORT_IN_LINK_INDICATOR,
  output logic PORT_OUT_LINK_INDICATOR,
  output logic STATUS_LED,
  output logic [1:0] ERR_DATA_O,
  output logic [1:0] ERR_DATA_OE
);
  import fieldbus_led_pkg::*;

  localparam int DIV_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam int NPORT = 2;

  // shared millisecond time base
  logic [DIV_W-1:0] div_r;
  logic div_wrap;
  logic ms_tick;

  assign div_wrap = (div_r == DIV_W'(MS_CYCLES - 1));
  assign ms_tick = div_wrap; // see R13

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      div_r <= '0;
    else if (div_wrap)
      div_r <= '0;
    else
      div_r <= div_r + DIV_W'(1);
  end

  // port indicators, one independent lane per port
  port_link_t port_sel [NPORT];
  logic [NPORT-1:0] port_led;

  assign port_sel[0] = PORT_IN; // see R03
  assign port_sel[1] = PORT_OUT; // see R03

  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      logic [`ACT_CNT_W-1:0] hold_r;
      logic [`ACT_CNT_W-1:0] hold_nxt;
      logic busy;
      pattern_t pat;

      // activity is stretched so single frames are still visible
      assign hold_nxt = !port_sel[p].link ? '0 :
                        port_sel[p].act ? `ACT_HOLD_MS :
                        (ms_tick && hold_r != '0) ? hold_r - `ACT_CNT_W'(1) : hold_r;
      assign busy = (hold_r != '0) || port_sel[p].act;
      assign pat = !port_sel[p].link ? PAT_OFF : // see R01
                   busy ? PAT_FLICKER : // see R02
                   PAT_ON; // see R01

      always_ff @(posedge REF_CLK or negedge RSTN)
      begin
        if (!RSTN)
          hold_r <= '0;
        else
          hold_r <= hold_nxt;
      end

      led_pattern_gen u_port_pat (
        .clk(REF_CLK),
        .rstn(RSTN),
        .ms_tick(ms_tick),
        .pattern(pat),
        .led(port_led[p])
      );
    end
  endgenerate

  assign PORT_IN_LINK_INDICATOR = port_led[0];
  assign PORT_OUT_LINK_INDICATOR = port_led[1];

  // status lamp
  logic booting_r;
  logic in_init;
  logic status_flicker;
  logic is_preop;
  logic is_safeop;
  logic is_boot;
  logic is_op;
  pattern_t status_pat;

  assign in_init = (AL_STATE == `AL_INIT);
  assign is_preop = (AL_STATE == `AL_PREOP);
  assign is_safeop = (AL_STATE == `AL_SAFEOP);
  assign is_boot = (AL_STATE == `AL_BOOT);
  assign is_op = (AL_STATE == `AL_OP);

  // booting lasts from reset until INIT is seen for the first time
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      booting_r <= 1'b1;
    else if (in_init)
      booting_r <= 1'b0;
  end

  assign status_flicker = booting_r || FW_DOWNLOAD || is_boot; // see R07
  assign status_pat = status_flicker ? PAT_FLICKER : // see R07
                      is_op ? PAT_ON : // see R04
                      is_safeop ? PAT_SINGLE : // see R06
                      is_preop ? PAT_BLINK : // see R05
                      PAT_OFF; // see R08

  led_pattern_gen u_status_pat (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ms_tick(ms_tick),
    .pattern(status_pat),
    .led(STATUS_LED)
  );

  // error lamp; watchdog and configuration errors are held until acknowledged
  logic wdog_r;
  logic cfg_r;
  logic boot_err;
  logic err_led;
  pattern_t err_pat;

  // a new event in the acknowledge cycle keeps its flag set
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wdog_r <= 1'b0;
      cfg_r <= 1'b0;
    end
    else
    begin
      wdog_r <= PDI_WDOG_TIMEOUT || (wdog_r && !ERROR_ACK); // see R09
      cfg_r <= CONFIG_ERROR || (cfg_r && !ERROR_ACK); // see R10
    end
  end

  assign boot_err = in_init && (AL_CHANGE_FLAG == `AL_CHANGE_ERROR); // see R11
  // a dead controller outranks everything, so steady on wins
  assign err_pat = wdog_r ? PAT_ON : // see R09
                   boot_err ? PAT_FLICKER : // see R11
                   cfg_r ? PAT_BLINK : // see R10
                   PAT_OFF;

  led_pattern_gen u_err_pat (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ms_tick(ms_tick),
    .pattern(err_pat),
    .led(err_led)
  );

  // lamp sinks current: both data lines pulled low while lit, released otherwise
  assign ERR_DATA_O = 2'h0; // see R12
  assign ERR_DATA_OE = {2{err_led}}; // see R12

endmodule : fieldbus_indicator_leds

`default_nettype wire

// File: fieldbus_led_map.svh
`ifndef FIELDBUS_LED_MAP_SVH
`define FIELDBUS_LED_MAP_SVH

// time base
`define REF_CLK_HZ 250000000
`define MS_PERIOD_US 1000

// pattern counter width and phase lengths in milliseconds
`define PAT_CNT_W 11
`define BLINK_ON_MS 11'h0c8
`define BLINK_OFF_MS 11'h0c8
`define SINGLE_ON_MS 11'h0c8
`define SINGLE_OFF_MS 11'h3e8
`define FLICKER_ON_MS 11'h032
`define FLICKER_OFF_MS 11'h032

// activity stretch so that short bursts still show as flicker
`define ACT_CNT_W 7
`define ACT_HOLD_MS 7'h64

// application-layer state codes on the state input
`define AL_STATE_W 4
`define AL_INIT 4'h1
`define AL_PREOP 4'h2
`define AL_BOOT 4'h3
`define AL_SAFEOP 4'h4
`define AL_OP 4'h8

// value of the status change indication that marks change/error
`define AL_CHANGE_ERROR 1'h1

`endif

// File: fieldbus_led_pkg.sv
package fieldbus_led_pkg;

  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_ON,
    PAT_BLINK,
    PAT_SINGLE,
    PAT_FLICKER
  } pattern_t;

  typedef struct packed {
    logic link;
    logic act;
  } port_link_t;

endpackage : fieldbus_led_pkg

// File: led_pattern_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_led_map.svh"

module led_pattern_gen (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ms_tick,
  input wire fieldbus_led_pkg::pattern_t pattern,
  output logic led
);
  import fieldbus_led_pkg::*;

  logic [`PAT_CNT_W-1:0] cnt_r;
  logic [`PAT_CNT_W-1:0] cnt_nxt;
  pattern_t prev_r;
  logic led_r;
  logic led_nxt;
  logic restart;
  logic wrap;
  logic [`PAT_CNT_W-1:0] on_len;
  logic [`PAT_CNT_W-1:0] per_len;

  assign on_len = (pattern == PAT_BLINK) ? `BLINK_ON_MS :
                  (pattern == PAT_SINGLE) ? `SINGLE_ON_MS : `FLICKER_ON_MS;
  assign per_len = (pattern == PAT_BLINK) ? `BLINK_ON_MS + `BLINK_OFF_MS :
                   (pattern == PAT_SINGLE) ? `SINGLE_ON_MS + `SINGLE_OFF_MS :
                   `FLICKER_ON_MS + `FLICKER_OFF_MS;

  // a new pattern starts in its on phase; the first phase may be short by
  // up to one tick because the shared tick is not realigned
  assign restart = (pattern != prev_r); // see R13
  assign wrap = (cnt_r >= per_len - `PAT_CNT_W'(1));
  assign cnt_nxt = restart ? '0 :
                   !ms_tick ? cnt_r :
                   wrap ? '0 : cnt_r + `PAT_CNT_W'(1); // see R13
  assign led_nxt = (pattern == PAT_OFF) ? 1'b0 :
                   (pattern == PAT_ON) ? 1'b1 :
                   (cnt_nxt < on_len); // see R05 see R06 see R07 see R10 see R11

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      prev_r <= PAT_OFF;
      led_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      prev_r <= pattern;
      led_r <= led_nxt;
    end
  end

  assign led = led_r;

endmodule : led_pattern_gen

`default_nettype wire

// File: fieldbus_leds_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_led_map.svh"
module fieldbus_leds_assertions (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire fieldbus_led_pkg::port_link_t PORT_IN,
  input wire fieldbus_led_pkg::port_link_t PORT_OUT,
  input wire logic [`AL_STATE_W-1:0] AL_STATE,
  input wire logic AL_CHANGE_FLAG,
  input wire logic FW_DOWNLOAD,
  input wire logic PDI_WDOG_TIMEOUT,
  input wire logic CONFIG_ERROR,
  input wire logic ERROR_ACK,
  input wire logic PORT_IN_LINK_INDICATOR,
  input wire logic PORT_OUT_LINK_INDICATOR,
  input wire logic STATUS_LED,
  input wire logic [1:0] ERR_DATA_O,
  input wire logic [1:0] ERR_DATA_OE
);
  import fieldbus_led_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  property p_err_o; ERR_DATA_O == 2'h0; endproperty
  a_err_o: assert property (p_err_o) else $error("data lines not held low");
  property p_oe_pair; ERR_DATA_OE[0] == ERR_DATA_OE[1]; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("data enables differ");
  property p_in_dark; !PORT_IN.link |=> !PORT_IN_LINK_INDICATOR; endproperty
  a_in_dark: assert property (p_in_dark) else $error("in indicator lit");
  property p_out_dark; !PORT_OUT.link |=> !PORT_OUT_LINK_INDICATOR; endproperty
  a_out_dark: assert property (p_out_dark) else $error("out indicator lit");
  property p_wdog_on; PDI_WDOG_TIMEOUT |-> ##2 ERR_DATA_OE == 2'h3; endproperty
  a_wdog_on: assert property (p_wdog_on) else $error("error led not lit");
  property p_ack_clear;
    (ERROR_ACK && !PDI_WDOG_TIMEOUT && !CONFIG_ERROR
      && !(AL_STATE == `AL_INIT && AL_CHANGE_FLAG))[*3] |-> ERR_DATA_OE == 2'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("error led stuck");
  property p_boot_lit; $rose(RSTN) && AL_STATE != `AL_INIT |-> ##[1:3] STATUS_LED; endproperty
  a_boot_lit: assert property (p_boot_lit) else $error("no boot flicker");
  property p_init_dark; (AL_STATE == `AL_INIT && !FW_DOWNLOAD)[*3] |-> !STATUS_LED; endproperty
  a_init_dark: assert property (p_init_dark) else $error("status lit in init");
endmodule : fieldbus_leds_assertions
bind fieldbus_indicator_leds fieldbus_leds_assertions fieldbus_leds_assertions_inst (.*);
`default_nettype wire

// File: led_jack_model.sv
`timescale 1ns/1ns
`default_nettype none
module led_jack_model (
  input wire logic [1:0] data_o,
  input wire logic [1:0] data_oe,
  output wire logic [1:0] data_line,
  output logic red_lit
);
  // pull-ups lift a released line, so a stale low never shows
  assign data_line = (data_oe & data_o) | ~data_oe;
  assign red_lit = (data_line == 2'h0);
endmodule : led_jack_model
`default_nettype wire

// File: tb_fieldbus_indicator_leds.sv
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_led_map.svh"
module tb_fieldbus_indicator_leds;
  import fieldbus_led_pkg::*;
  localparam int MS = 10;
  logic ref_clk = 1'h0, rstn = 1'h0, chg = 1'h0, fw = 1'h0, wdog = 1'h0, cfg = 1'h0, ack = 1'h0;
  port_link_t port_in = '0, port_out = '0;
  logic [3:0] al_state = 4'h0;
  logic in_ind, out_ind, status, red;
  logic [1:0] d_o, d_oe, line;
  wire logic [3:0] leds;
  int n_errors = 0, comparisons = 0;
  assign leds = {out_ind, in_ind, red, status};
  // outputs are sampled half a cycle after they launch, never at the launching edge
  logic [3:0] leds_s = 4'h0;
  always @(negedge ref_clk) leds_s <= leds;
  always #2 ref_clk = ~ref_clk;
  fieldbus_indicator_leds #(.MS_CYCLES(MS)) fieldbus_indicator_leds_inst (.REF_CLK(ref_clk),
    .RSTN(rstn), .PORT_IN(port_in), .PORT_OUT(port_out), .AL_STATE(al_state),
    .AL_CHANGE_FLAG(chg), .FW_DOWNLOAD(fw), .PDI_WDOG_TIMEOUT(wdog), .CONFIG_ERROR(cfg),
    .ERROR_ACK(ack), .PORT_IN_LINK_INDICATOR(in_ind), .PORT_OUT_LINK_INDICATOR(out_ind),
    .STATUS_LED(status), .ERR_DATA_O(d_o), .ERR_DATA_OE(d_oe));
  led_jack_model led_jack_model_inst (.data_o(d_o), .data_oe(d_oe), .data_line(line),
    .red_lit(red));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  // first on phase may be up to one tick short, so probes keep a margin
  task automatic pat(input int idx, input int on, input int off);
    tick(3);
    chk("led on", 1'h1, leds_s[idx]);
    tick((on - 1) * MS - 8);
    chk("led on", 1'h1, leds_s[idx]);
    tick(20);
    chk("led off", 1'h0, leds_s[idx]);
    tick(off * MS - 30);
    chk("led off", 1'h0, leds_s[idx]);
    tick(30);
    chk("led on", 1'h1, leds_s[idx]);
  endtask : pat
  task automatic t_status;
    logic [3:0] st [3] = '{`AL_PREOP, `AL_SAFEOP, `AL_BOOT};
    int on_t [3] = '{200, 200, 50};
    int off_t [3] = '{200, 1000, 50};
    al_state <= `AL_INIT;
    chg <= 1'h1;
    pat(1, 50, 50);
    chk("status", 1'h0, leds_s[0]);
    chg <= 1'h0;
    foreach (st[i])
    begin
      al_state <= st[i];
      pat(0, on_t[i], off_t[i]);
    end
    al_state <= `AL_OP;
    tick(3);
    chk("status", 1'h1, leds_s[0]);
    fw <= 1'h1;
    pat(0, 50, 50);
    fw <= 1'h0;
    $display("status test done");
  endtask : t_status
  task automatic t_errors;
    cfg <= 1'h1;
    tick(1);
    cfg <= 1'h0;
    pat(1, 200, 200);
    wdog <= 1'h1;
    tick(1);
    wdog <= 1'h0;
    tick(3);
    chk("red", 1'h1, leds_s[1]);
    tick(2500);
    chk("red", 1'h1, leds_s[1]);
    ack <= 1'h1;
    tick(3);
    ack <= 1'h0;
    tick(3);
    chk("red", 1'h0, leds_s[1]);
    $display("error test done");
  endtask : t_errors
  task automatic t_ports;
    port_in <= 2'h2;
    tick(3);
    chk("in", 1'h1, leds_s[2]);
    chk("out", 1'h0, leds_s[3]);
    port_in <= 2'h3;
    tick(1);
    port_in <= 2'h2;
    pat(2, 50, 50);
    chk("out", 1'h0, leds_s[3]);
    port_in <= 2'h0;
    port_out <= 2'h3;
    pat(3, 50, 50);
    chk("in", 1'h0, leds_s[2]);
    $display("port test done");
  endtask : t_ports
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial
  begin
    tick(20);
    rstn <= 1'h1;
    pat(0, 50, 50);
    $display("boot test done");
    t_status();
    t_errors();
    t_ports();
    conclude();
  end
endmodule : tb_fieldbus_indicator_leds
`default_nettype wire
